// *** icb_capture_top.sv ***
// input capture block with two time bases and an axi4-lite register slave
// What this block does
// - capture selected 16-bit time base on event
// - falling mode captures every falling edge
// - rising mode captures every rising edge
// - both-edges mode captures every transition
// - first prescaled mode captures every fourth rise
// - second prescaled mode captures every sixteenth rise
// - two independent channels, own input pins
// - each channel selects one of two bases
// - time base counts internal or external clock
// - four-entry fifo per channel
// - interrupt after one to four entries
// - interrupt request on capture per fill setting
// - capture event wakes sleeping or idle cpu
// - channel serves as extra external interrupt
// - first and second bases join into 32 bits
// - first base synchronises after its prescaler
// - second base synchronises before its prescaler
module icb_capture_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] capture_input_pin,
    input wire logic [1:0] time_base_ext_clock_pin,
    input wire logic cpu_low_power,
    output logic irq,
    output logic wake_req
);
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && (a <= icb_pkg::OFF_INT_ENABLE);
    endfunction : is_mapped

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++)
        begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction : merge

    function automatic logic ps_hit(input logic [7:0] cnt, input logic [1:0] code);
        case (code)
            2'd0: ps_hit = (cnt == icb_pkg::PS_LAST_1);
            2'd1: ps_hit = (cnt == icb_pkg::PS_LAST_8);
            2'd2: ps_hit = (cnt == icb_pkg::PS_LAST_64);
            default: ps_hit = (cnt == icb_pkg::PS_LAST_256);
        endcase
    endfunction : ps_hit

    icb_pkg::icb_tb_cfg_t tb_cfg;
    icb_pkg::icb_chan_cfg_t ch_cfg [2];
    logic [15:0] tb1;
    logic [15:0] tb2;
    logic [7:0] ps1;
    logic [7:0] ps2;
    logic t1_pin_q, t1_pin_d, t1_tog, t1_ts1, t1_ts2, t1_ts3;
    logic t2_s1, t2_s2, t2_d;
    logic src1, src2, hit1, hit2, tick1, tick2, tick2_eff;
    logic [1:0] cap_s1, cap_s2, cap_d, rise, fall, cap_ev, push, pop;
    logic [3:0] ev_cnt [2];
    logic [15:0] fifo_mem [2][4];
    logic [1:0] wp [2];
    logic [1:0] rp [2];
    logic [2:0] cnt [2];
    logic [5:0] int_st;
    logic [5:0] int_en;
    logic [5:0] int_set;
    logic wr_hs, rd_hs;
    logic [15:0] cap_val [2];

    // write channel takes address and data together
    assign wr_hs = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_hs;
    assign s_axi_wready = wr_hs;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_hs = s_axi_arvalid && s_axi_arready;

    // first base: count source prescaled, then resynchronised via toggle
    assign src1 = tb_cfg.tb1_ext ? (t1_pin_q && !t1_pin_d) : 1'b1;
    assign hit1 = tb_cfg.tb1_en && src1 && ps_hit(ps1, tb_cfg.tb1_ps);
    assign tick1 = tb_cfg.tb1_ext ? (t1_ts2 ^ t1_ts3) : hit1;
    // second base: pin synchronised first, then prescaled
    assign src2 = tb_cfg.tb2_ext ? (t2_s2 && !t2_d) : 1'b1;
    assign hit2 = tb_cfg.tb2_en && src2 && ps_hit(ps2, tb_cfg.tb2_ps);
    assign tick2 = hit2;
    assign tick2_eff = tb_cfg.concat ? (tick1 && tb1 == icb_pkg::TB_MAX) : tick2;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            t1_pin_q <= 1'b0;
            t1_pin_d <= 1'b0;
            t1_tog <= 1'b0;
            t1_ts1 <= 1'b0;
            t1_ts2 <= 1'b0;
            t1_ts3 <= 1'b0;
            t2_s1 <= 1'b0;
            t2_s2 <= 1'b0;
            t2_d <= 1'b0;
            ps1 <= 8'h00;
            ps2 <= 8'h00;
        end
        else
        begin
            t1_pin_q <= time_base_ext_clock_pin[0];
            t1_pin_d <= t1_pin_q;
            t1_tog <= t1_tog ^ (hit1 && tb_cfg.tb1_ext);
            t1_ts1 <= t1_tog;
            t1_ts2 <= t1_ts1;
            t1_ts3 <= t1_ts2;
            t2_s1 <= time_base_ext_clock_pin[1];
            t2_s2 <= t2_s1;
            t2_d <= t2_s2;
            if (tb_cfg.tb1_en && src1)
            begin
                ps1 <= hit1 ? 8'h00 : ps1 + 8'h01;
            end
            if (tb_cfg.tb2_en && src2)
            begin
                ps2 <= hit2 ? 8'h00 : ps2 + 8'h01;
            end
        end
    end

    // time base counters, writable from the bus
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tb1 <= 16'h0000;
            tb2 <= 16'h0000;
        end
        else
        begin
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_TB1_COUNT)
                tb1 <= 16'(merge({16'h0000, tb1}, s_axi_wdata, s_axi_wstrb));
            else if (tick1)
                tb1 <= tb1 + 16'h0001;
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_TB2_COUNT)
                tb2 <= 16'(merge({16'h0000, tb2}, s_axi_wdata, s_axi_wstrb));
            else if (tick2_eff)
                tb2 <= tb2 + 16'h0001;
        end
    end

    // capture pin synchroniser and edge detect
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cap_s1 <= 2'b00;
            cap_s2 <= 2'b00;
            cap_d <= 2'b00;
        end
        else
        begin
            cap_s1 <= capture_input_pin;
            cap_s2 <= cap_s1;
            cap_d <= cap_s2;
        end
    end
    assign rise = cap_s2 & ~cap_d;
    assign fall = ~cap_s2 & cap_d;

    // event qualification per channel mode
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            cap_val[c] = ch_cfg[c].tb_sel ? tb2 : tb1;
            case (ch_cfg[c].mode)
                icb_pkg::ICB_EVERY_EDGE: cap_ev[c] = rise[c] || fall[c];
                icb_pkg::ICB_FALL: cap_ev[c] = fall[c];
                icb_pkg::ICB_RISE: cap_ev[c] = rise[c];
                icb_pkg::ICB_RISE_4TH: cap_ev[c] = rise[c] && ev_cnt[c][1:0] == icb_pkg::EV_LAST_4TH[1:0];
                icb_pkg::ICB_RISE_16TH: cap_ev[c] = rise[c] && ev_cnt[c] == icb_pkg::EV_LAST_16TH;
                default: cap_ev[c] = 1'b0;
            endcase
            push[c] = cap_ev[c] && cnt[c] != icb_pkg::FIFO_FULL;
            pop[c] = rd_hs && cnt[c] != 3'h0
                && s_axi_araddr == (c == 0 ? icb_pkg::OFF_CH0_FIFO : icb_pkg::OFF_CH1_FIFO);
        end
    end

    // rising edge counters for prescaled modes, restarted on config write
    always_ff @(posedge aclk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!aresetn)
                ev_cnt[c] <= 4'h0;
            else if (wr_hs && s_axi_awaddr == (c == 0 ? icb_pkg::OFF_CH0_CTRL : icb_pkg::OFF_CH1_CTRL))
                ev_cnt[c] <= 4'h0;
            else if (rise[c])
                ev_cnt[c] <= ev_cnt[c] + 4'h1;
        end
    end

    // capture fifos
    always_ff @(posedge aclk)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!aresetn)
            begin
                wp[c] <= 2'h0;
                rp[c] <= 2'h0;
                cnt[c] <= 3'h0;
            end
            else
            begin
                if (push[c])
                begin
                    fifo_mem[c][wp[c]] <= cap_val[c];
                    wp[c] <= wp[c] + 2'h1;
                end
                if (pop[c])
                    rp[c] <= rp[c] + 2'h1;
                if (push[c] && !pop[c])
                    cnt[c] <= cnt[c] + 3'h1;
                else if (pop[c] && !push[c])
                    cnt[c] <= cnt[c] - 3'h1;
            end
        end
    end

    // interrupt event sources
    always_comb
    begin
        int_set = 6'h00;
        for (int c = 0; c < 2; c++)
        begin
            int_set[icb_pkg::ST_FILL + c] = push[c] && (cnt[c] + 3'h1) > {1'b0, ch_cfg[c].fill_level};
            int_set[icb_pkg::ST_OVF + c] = cap_ev[c] && !push[c];
            int_set[icb_pkg::ST_EDGE + c] = cap_ev[c];
        end
    end

    // configuration, sticky status and wake
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tb_cfg <= '0;
            ch_cfg[0] <= '0;
            ch_cfg[1] <= '0;
            int_en <= 6'h00;
            int_st <= 6'h00;
            wake_req <= 1'b0;
        end
        else
        begin
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_TB_CTRL)
                tb_cfg <= icb_pkg::icb_tb_cfg_t'(9'(merge({23'h0, tb_cfg}, s_axi_wdata, s_axi_wstrb)));
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_CH0_CTRL)
                ch_cfg[0] <= icb_pkg::icb_chan_cfg_t'(6'(merge({26'h0, ch_cfg[0]}, s_axi_wdata, s_axi_wstrb)));
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_CH1_CTRL)
                ch_cfg[1] <= icb_pkg::icb_chan_cfg_t'(6'(merge({26'h0, ch_cfg[1]}, s_axi_wdata, s_axi_wstrb)));
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_INT_ENABLE)
                int_en <= 6'(merge({26'h0, int_en}, s_axi_wdata, s_axi_wstrb));
            // set wins over a clear in the same cycle
            if (wr_hs && s_axi_awaddr == icb_pkg::OFF_INT_CLEAR && s_axi_wstrb[0])
                int_st <= (int_st & ~s_axi_wdata[5:0]) | int_set;
            else
                int_st <= int_st | int_set;
            wake_req <= cpu_low_power && |cap_ev;
        end
    end
    assign irq = |(int_st & int_en);

    // bus responses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= icb_pkg::RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= icb_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end
        else
        begin
            if (wr_hs)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(s_axi_awaddr) ? icb_pkg::RESP_OKAY : icb_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? icb_pkg::RESP_OKAY : icb_pkg::RESP_SLVERR;
                case (s_axi_araddr)
                    icb_pkg::OFF_TB_CTRL: s_axi_rdata <= {23'h0, tb_cfg};
                    icb_pkg::OFF_TB1_COUNT: s_axi_rdata <= {16'h0, tb1};
                    icb_pkg::OFF_TB2_COUNT: s_axi_rdata <= {16'h0, tb2};
                    icb_pkg::OFF_CH0_CTRL: s_axi_rdata <= {26'h0, ch_cfg[0]};
                    icb_pkg::OFF_CH1_CTRL: s_axi_rdata <= {26'h0, ch_cfg[1]};
                    icb_pkg::OFF_CH0_FIFO: s_axi_rdata <= pop[0] ? {16'h0, fifo_mem[0][rp[0]]} : 32'h0;
                    icb_pkg::OFF_CH1_FIFO: s_axi_rdata <= pop[1] ? {16'h0, fifo_mem[1][rp[1]]} : 32'h0;
                    icb_pkg::OFF_CH_STATUS: s_axi_rdata <= {25'h0, cnt[1], 1'b0, cnt[0]};
                    icb_pkg::OFF_INT_STATUS: s_axi_rdata <= {26'h0, int_st};
                    icb_pkg::OFF_INT_ENABLE: s_axi_rdata <= {26'h0, int_en};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_capture_value: assert property (push[0] |=> fifo_mem[0][$past(wp[0])] == $past(cap_val[0]))
        else $error("captured value differs from time base");
    a_fall_capture: assert property (ch_cfg[0].mode == icb_pkg::ICB_FALL && fall[0] |-> cap_ev[0])
        else $error("falling edge not captured");
    a_rise_capture: assert property (ch_cfg[0].mode == icb_pkg::ICB_RISE |-> cap_ev[0] == rise[0])
        else $error("rising mode capture mismatch");
    a_both_capture: assert property (ch_cfg[0].mode == icb_pkg::ICB_EVERY_EDGE
        && (rise[0] || fall[0]) |-> cap_ev[0])
        else $error("edge missed in both-edge mode");
    a_fourth_rise: assert property (ch_cfg[0].mode == icb_pkg::ICB_RISE_4TH && cap_ev[0]
        |-> ev_cnt[0][1:0] == 2'h3)
        else $error("prescaled capture not on fourth rise");
    a_sixteenth_rise: assert property (ch_cfg[0].mode == icb_pkg::ICB_RISE_16TH && cap_ev[0]
        |-> ev_cnt[0] == 4'hF)
        else $error("prescaled capture not on sixteenth rise");
    a_fifo_count: assert property (push[0] && !pop[0] |=> cnt[0] == $past(cnt[0]) + 3'h1)
        else $error("fifo count did not advance");
    a_fill_flag: assert property (push[0] && cnt[0] == {1'b0, ch_cfg[0].fill_level} |=> int_st[0])
        else $error("fill interrupt not raised");
    a_irq_out: assert property (int_st[0] && int_en[0] |-> irq)
        else $error("enabled status did not raise irq");
    a_wake_pulse: assert property (cpu_low_power && cap_ev[1] |=> wake_req)
        else $error("no wake on capture");
    a_concat_carry: assert property (tb_cfg.concat && tick1 && tb1 == 16'hFFFF
        && !(wr_hs && s_axi_awaddr == icb_pkg::OFF_TB2_COUNT) |=> tb2 == $past(tb2) + 16'h1)
        else $error("no carry into second base");
    a_tb1_sync_delay: assert property (tb_cfg.tb1_ext && hit1 ##1 $stable(tb_cfg)[*3] |-> tick1)
        else $error("first base tick not after synchroniser");
    a_pin_sync: assert property ($rose(capture_input_pin[0]) ##1 capture_input_pin[0] |-> ##1 rise[0])
        else $error("pin edge not detected two cycles later");
    a_overflow_flag: assert property (cap_ev[0] && cnt[0] == 3'h4 |=> int_st[2] && cnt[0] != 3'h5)
        else $error("overflow not flagged");

    c_fifo_full: cover property (push[0] && cnt[0] == 3'h3);
    c_overflow: cover property (cap_ev[0] && cnt[0] == 3'h4);
    c_concat_wrap: cover property (tb_cfg.concat && tick1 && tb1 == 16'hFFFF);
    c_prescaled16: cover property (ch_cfg[0].mode == icb_pkg::ICB_RISE_16TH && cap_ev[0]);
    c_ext_tick: cover property (tb_cfg.tb1_ext && tick1);
endmodule : icb_capture_top

// *** icb_pkg.sv ***
// shared constants, field layouts and carrier types of the input capture block
package icb_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned TB_W = 16;
    localparam int unsigned NUM_CH = 2;
    localparam int unsigned FIFO_DEPTH = 4;
    // register byte offsets
    localparam logic [7:0] OFF_TB_CTRL = 8'h00;
    localparam logic [7:0] OFF_TB1_COUNT = 8'h04;
    localparam logic [7:0] OFF_TB2_COUNT = 8'h08;
    localparam logic [7:0] OFF_CH0_CTRL = 8'h0C;
    localparam logic [7:0] OFF_CH1_CTRL = 8'h10;
    localparam logic [7:0] OFF_CH0_FIFO = 8'h14;
    localparam logic [7:0] OFF_CH1_FIFO = 8'h18;
    localparam logic [7:0] OFF_CH_STATUS = 8'h1C;
    localparam logic [7:0] OFF_INT_STATUS = 8'h20;
    localparam logic [7:0] OFF_INT_CLEAR = 8'h24;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h28;
    // interrupt status layout: fill[1:0], overflow[3:2], pin event[5:4]
    localparam int unsigned INT_W = 6;
    localparam int unsigned ST_FILL = 0;
    localparam int unsigned ST_OVF = 2;
    localparam int unsigned ST_EDGE = 4;
    // channel status layout: count0 [2:0], count1 [6:4]
    localparam int unsigned CS_CNT1 = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [15:0] TB_MAX = 16'hFFFF;
    localparam logic [2:0] FIFO_FULL = 3'h4;
    localparam logic [3:0] EV_LAST_4TH = 4'h3;
    localparam logic [3:0] EV_LAST_16TH = 4'hF;
    // prescaler terminal counts for ratios 1, 8, 64, 256
    localparam logic [7:0] PS_LAST_1 = 8'h00;
    localparam logic [7:0] PS_LAST_8 = 8'h07;
    localparam logic [7:0] PS_LAST_64 = 8'h3F;
    localparam logic [7:0] PS_LAST_256 = 8'hFF;

    typedef enum logic [2:0] {
        ICB_OFF,
        ICB_EVERY_EDGE,
        ICB_FALL,
        ICB_RISE,
        ICB_RISE_4TH,
        ICB_RISE_16TH
    } icb_mode_t;

    typedef struct packed {
        logic [1:0] fill_level;
        logic tb_sel;
        icb_mode_t mode;
    } icb_chan_cfg_t;

    typedef struct packed {
        logic concat;
        logic [1:0] tb2_ps;
        logic tb2_ext;
        logic tb2_en;
        logic [1:0] tb1_ps;
        logic tb1_ext;
        logic tb1_en;
    } icb_tb_cfg_t;
endpackage : icb_pkg

// *** icb_pin_source.sv ***
// pin-level source model for capture inputs and external time base clocks
module icb_pin_source (
    input wire logic aclk,
    output logic [1:0] cap_pin,
    output logic [1:0] ext_clk
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        cap_pin = 2'b00;
        ext_clk = 2'b00;
    end

    // one high phase then one low phase; mask bits [1:0] capture, [3:2] ext clock
    task automatic drive(input logic [3:0] m, input int hi, input int lo);
        {ext_clk, cap_pin} <= m;
        repeat (hi) @(posedge aclk);
        {ext_clk, cap_pin} <= 4'h0;
        repeat (lo) @(posedge aclk);
    endtask : drive
endmodule : icb_pin_source

// *** test_icb_capture_top.sv ***
// self-checking bench for the input capture block
module test_icb_capture_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic cpu_low_power = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req;
    logic [1:0] bresp, rresp, cap_pin, ext_clk;
    logic [31:0] rdata;
    logic [33:0] exq[$];
    int fails = 0;
    int compares = 0;
    int wakes = 0;
    int seed = 32'h68AF9943;

    always #5 aclk = ~aclk;

    icb_capture_top u_icb_capture_top (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
        .capture_input_pin(cap_pin), .time_base_ext_clock_pin(ext_clk),
        .cpu_low_power(cpu_low_power), .irq(irq), .wake_req(wake_req)
    );

    icb_pin_source u_icb_pin_source (.aclk(aclk), .cap_pin(cap_pin), .ext_clk(ext_clk));

    task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] s);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask : cmp

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = icb_pkg::RESP_OKAY);
        exq.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = icb_pkg::RESP_OKAY);
        exq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
    endtask : rd

    task automatic tdone(input string name);
        $display("test %s done", name);
    endtask : tdone

    // response monitor: oldest note against each answer
    always @(posedge aclk)
    begin
        if (bvalid === 1'b1)
            cmp("write response", exq.pop_front(), {bresp, 32'h0});
        if (rvalid === 1'b1)
            cmp("read data", exq.pop_front(), {rresp, rdata});
    end

    always @(posedge aclk)
    begin
        if (wake_req === 1'b1)
            wakes++;
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        fails++;
        end_of_test();
    end

    initial
    begin : main
        static icb_pkg::icb_mode_t modes[5] = '{icb_pkg::ICB_EVERY_EDGE, icb_pkg::ICB_FALL, icb_pkg::ICB_RISE,
            icb_pkg::ICB_RISE_4TH, icb_pkg::ICB_RISE_16TH};
        static int np[5] = '{1, 3, 2, 8, 16};
        static int ne[5] = '{2, 3, 2, 2, 1};
        logic [15:0] v;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(icb_pkg::OFF_INT_STATUS, 32'h0);
        rd(icb_pkg::OFF_CH_STATUS, 32'h0);
        rd(8'h2C, 32'h0, icb_pkg::RESP_SLVERR);
        wr(8'h2C, 32'hFFFFFFFF, icb_pkg::RESP_SLVERR);
        tdone("reset and map");
        cpu_low_power <= 1'b1;
        for (int ch = 0; ch < 2; ch++)
        begin
            for (int m = 0; m < 5; m++)
            begin
                v = 16'($random(seed));
                wr(8'(icb_pkg::OFF_TB1_COUNT + 4 * ch), {16'h0, v});
                wr(8'(icb_pkg::OFF_CH0_CTRL + 4 * ch), 32'(((ne[m] - 1) << 4) | (ch << 3) | modes[m]));
                wr(icb_pkg::OFF_INT_CLEAR, 32'h3F);
                wr(icb_pkg::OFF_INT_ENABLE, 32'(1 << ch));
                repeat (np[m]) u_icb_pin_source.drive(4'(1 << ch), 3 + ($random(seed) & 7), 3 + ($random(seed) & 7));
                repeat (8) @(posedge aclk);
                cmp("irq set", 34'h1, {33'h0, irq});
                rd(icb_pkg::OFF_CH_STATUS, 32'(ne[m] << (4 * ch)));
                rd(icb_pkg::OFF_INT_STATUS, 32'((1 << ch) | (16 << ch)));
                repeat (ne[m]) rd(8'(icb_pkg::OFF_CH0_FIFO + 4 * ch), {16'h0, v});
                rd(8'(icb_pkg::OFF_CH0_FIFO + 4 * ch), 32'h0);
                wr(icb_pkg::OFF_INT_CLEAR, 32'h3F);
                cmp("irq clear", 34'h0, {33'h0, irq});
            end
        end
        cmp("wake pulses", 34'd20, 34'(wakes));
        tdone("capture modes");
        cpu_low_power <= 1'b0;
        wr(icb_pkg::OFF_TB1_COUNT, {16'h0, v});
        wr(icb_pkg::OFF_CH0_CTRL, 32'h33);
        wr(icb_pkg::OFF_INT_CLEAR, 32'h3F);
        repeat (5) u_icb_pin_source.drive(4'h1, 4, 4);
        repeat (8) @(posedge aclk);
        rd(icb_pkg::OFF_CH_STATUS, 32'h4);
        rd(icb_pkg::OFF_INT_STATUS, 32'h15);
        repeat (4) rd(icb_pkg::OFF_CH0_FIFO, {16'h0, v});
        cmp("wake idle", 34'd20, 34'(wakes));
        tdone("overflow");
        wr(icb_pkg::OFF_TB1_COUNT, 32'h0);
        wr(icb_pkg::OFF_TB2_COUNT, 32'h0);
        wr(icb_pkg::OFF_TB_CTRL, 32'h33);
        repeat (5) u_icb_pin_source.drive(4'hC, 3 + ($random(seed) & 7), 3 + ($random(seed) & 7));
        repeat (8) @(posedge aclk);
        wr(icb_pkg::OFF_TB_CTRL, 32'h0);
        rd(icb_pkg::OFF_TB1_COUNT, 32'h5);
        rd(icb_pkg::OFF_TB2_COUNT, 32'h5);
        tdone("external clocks");
        wr(icb_pkg::OFF_TB1_COUNT, 32'hFFFF);
        wr(icb_pkg::OFF_TB2_COUNT, 32'h0);
        wr(icb_pkg::OFF_TB_CTRL, 32'h11D);
        repeat (300) @(posedge aclk);
        wr(icb_pkg::OFF_TB_CTRL, 32'h0);
        rd(icb_pkg::OFF_TB2_COUNT, 32'h1);
        tdone("concatenation");
        // mid-run reset, then internal clock through the /8 and /64 prescalers
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(icb_pkg::OFF_INT_STATUS, 32'h0);
        rd(icb_pkg::OFF_TB2_COUNT, 32'h0);
        wr(icb_pkg::OFF_TB_CTRL, 32'h95);
        repeat (200) @(posedge aclk);
        wr(icb_pkg::OFF_TB_CTRL, 32'h0);
        rd(icb_pkg::OFF_TB1_COUNT, 32'h19);
        rd(icb_pkg::OFF_TB2_COUNT, 32'h3);
        tdone("internal prescalers");
        end_of_test();
    end
endmodule : test_icb_capture_top
